// ===== common/twi_pkg.sv
// Shared constants for the two-wire expander link: both ends import this package.
// Assumes a single 100 MHz system clock on each end.
package twi_pkg;
  localparam int          CLK_HZ          = 100_000_000;
  localparam int          SCL_HZ          = 100_000;
  localparam int          QUARTER_CYC     = CLK_HZ / (SCL_HZ * 4);
  localparam int          BYTE_BITS       = 8;
  localparam int          ADDR_BITS       = 7;
  localparam logic [3:0]  ADDR_FIXED      = 4'h4;
  localparam int          DIR_POS         = 0;
  localparam int          REG_COUNT       = 8;
  localparam int          CMD_BITS        = 3;
  localparam logic [7:0]  REG_RESET       = 8'h00;
  localparam logic [7:0]  CFG_RESET       = 8'hFF;
  localparam logic [2:0]  CFG_FIRST       = 3'h6;
endpackage : twi_pkg

// ===== common/twi_if.sv
// Open-drain two-wire bus joining the master end and the expander end.
// Each party drives only an enable that pulls its line low; the wire level is the wired AND.
interface twi_if;
  logic scl_oe_m;
  logic sda_oe_m;
  logic sda_oe_s;
  logic scl;
  logic sda;
  assign scl = ~scl_oe_m;
  assign sda = ~(sda_oe_m | sda_oe_s);
  modport master (input scl, input sda, output scl_oe_m, output sda_oe_m);
  modport slave  (input scl, input sda, output sda_oe_s);
endinterface : twi_if

// ===== src/sync2.sv
// Two flip-flop synchroniser for a level from outside the clock domain.
// Assumes the input may change at any time; only the second stage is read.
module sync2
  import twi_pkg::*;
#(
  parameter logic RESET_VAL = 1'b1
)
(
  input  wire logic clk_i,
  input  wire logic arst_n_i,
  input  wire logic d_i,
  output logic      q_o
);
  logic meta_r;

  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      meta_r <= RESET_VAL;
      q_o    <= RESET_VAL;
    end
    else
    begin
      meta_r <= d_i;
      q_o    <= meta_r;
    end
  end
endmodule : sync2

// ===== src/twi_expander.sv
// Expander end of the two-wire link: address match, command byte and register pair access.
// Assumes the bus lines are sampled by clk_i, much faster than the serial clock.
// Notes on behaviour
// - Master starts transfers only on an idle bus.
// - One data bit per serial clock pulse.
// - Data held steady while clock is high.
// - Data change with clock high is control.
// - Both lines released high when idle.
// - Falling data, clock high: start, take address.
// - Rising data, clock high: stop, go idle.
// - Eight bits then one acknowledge slot.
// - Unlimited bytes per transaction.
// - Master clocks an extra acknowledge pulse.
// - Acknowledge every byte received when addressed.
// - Master acknowledges read bytes except last.
// - Acknowledger holds data low through pulse.
// - Master ends read by withholding acknowledge.
// - On no acknowledge release data, stop driving.
// - Write: address, direction low, then command.
// - Read: repeated start, address with direction high.
// - Written bytes alternate within register pair.
// - Read bytes alternate within register pair.
module twi_expander
  import twi_pkg::*;
(
  input  wire logic       clk_i,
  input  wire logic       arst_n_i,
  twi_if.slave            bus,
  input  wire logic [2:0] addr_pins_i,
  input  wire logic [15:0] port_in_i,
  output logic [15:0]     port_out_o,
  output logic [15:0]     port_cfg_o,
  output logic            busy_o
);
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_ADDR  = 3'b001,
    ST_CMD   = 3'b010,
    ST_WDATA = 3'b011,
    ST_RDATA = 3'b100,
    ST_ACK   = 3'b101,
    ST_MACK  = 3'b110,
    ST_SKIP  = 3'b111
  } state_e;

  logic                scl_s;
  logic                sda_s;
  logic                scl_d_r;
  logic                sda_d_r;
  state_e              state_r;
  state_e              after_ack_r;
  logic [7:0]          shift_r;
  logic [3:0]          bit_cnt_r;
  logic [CMD_BITS-1:0] cmd_r;
  logic                rd_r;
  logic                sda_oe_r;
  logic [7:0]          regs_r [REG_COUNT];
  logic [18:0]         pins_raw;
  logic [18:0]         pins_s;
  logic [15:0]         port_in_s;
  logic [2:0]          addr_pins_s;
  logic                start_ev;
  logic                stop_ev;
  logic                scl_rise;
  logic                scl_fall;
  logic [7:0]          rx_byte;

  sync2 #(.RESET_VAL(1'b1)) u_sync_scl (.clk_i(clk_i), .arst_n_i(arst_n_i), .d_i(bus.scl), .q_o(scl_s));
  sync2 #(.RESET_VAL(1'b1)) u_sync_sda (.clk_i(clk_i), .arst_n_i(arst_n_i), .d_i(bus.sda), .q_o(sda_s));

  // Address straps and port pins are asynchronous to clk_i, so every bit passes two flip-flops first.
  assign pins_raw = {addr_pins_i, port_in_i};
  generate
    for (genvar g = 0; g < $bits(pins_raw); g++)
    begin : g_pin_sync
      sync2 #(.RESET_VAL(1'b0)) u_sync_pin (.clk_i(clk_i), .arst_n_i(arst_n_i), .d_i(pins_raw[g]), .q_o(pins_s[g]));
    end
  endgenerate
  assign port_in_s   = pins_s[15:0];
  assign addr_pins_s = pins_s[18:16];

  // Edge detection runs only on synchronised copies.
  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      scl_d_r <= 1'b1;
      sda_d_r <= 1'b1;
    end
    else
    begin
      scl_d_r <= scl_s;
      sda_d_r <= sda_s;
    end
  end

  assign start_ev = scl_s && scl_d_r && sda_d_r && !sda_s;
  assign stop_ev  = scl_s && scl_d_r && !sda_d_r && sda_s;
  assign scl_rise = scl_s && !scl_d_r;
  assign scl_fall = !scl_s && scl_d_r;
  assign rx_byte  = {shift_r[6:0], sda_s};

  function automatic logic [CMD_BITS-1:0] pair_flip(input logic [CMD_BITS-1:0] c);
    pair_flip = {c[CMD_BITS-1:1], ~c[0]};
  endfunction : pair_flip

  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      state_r     <= ST_IDLE;
      after_ack_r <= ST_IDLE;
      shift_r     <= 8'h00;
      bit_cnt_r   <= 4'h0;
      cmd_r       <= '0;
      rd_r        <= 1'b0;
      sda_oe_r    <= 1'b0;
      for (int i = 0; i < REG_COUNT; i++)
      begin
        regs_r[i] <= (i >= int'(CFG_FIRST)) ? CFG_RESET : REG_RESET;
      end
    end
    else if (stop_ev)
    begin
      state_r  <= ST_IDLE;
      sda_oe_r <= 1'b0;
    end
    else if (start_ev)
    begin
      state_r   <= ST_ADDR;
      bit_cnt_r <= 4'h0;
      sda_oe_r  <= 1'b0;
    end
    else
    begin
      case (state_r)
        ST_IDLE, ST_SKIP:
        begin
          sda_oe_r <= 1'b0;
        end
        ST_ADDR, ST_CMD, ST_WDATA:
        begin
          if (scl_rise)
          begin
            shift_r   <= rx_byte;
            bit_cnt_r <= bit_cnt_r + 4'h1;
          end
          else if (scl_fall && bit_cnt_r == 4'(BYTE_BITS))
          begin
            bit_cnt_r <= 4'h0;
            if (state_r == ST_ADDR)
            begin
              if (shift_r[7:1] == {ADDR_FIXED, addr_pins_s})
              begin
                sda_oe_r    <= 1'b1;
                rd_r        <= shift_r[DIR_POS];
                state_r     <= ST_ACK;
                after_ack_r <= shift_r[DIR_POS] ? ST_RDATA : ST_CMD;
              end
              else
              begin
                state_r <= ST_SKIP;
              end
            end
            else
            begin
              sda_oe_r <= 1'b1;
              state_r  <= ST_ACK;
              after_ack_r <= ST_WDATA;
              if (state_r == ST_CMD)
              begin
                cmd_r <= shift_r[CMD_BITS-1:0];
              end
              else
              begin
                // Input registers are read only, so writes to them are dropped.
                if (cmd_r[CMD_BITS-1:1] != '0)
                begin
                  regs_r[cmd_r] <= shift_r;
                end
                cmd_r <= pair_flip(cmd_r);
              end
            end
          end
        end
        ST_ACK:
        begin
          // Hold the acknowledge low through the whole high phase of its pulse.
          if (scl_fall)
          begin
            state_r  <= after_ack_r;
            sda_oe_r <= 1'b0;
            if (after_ack_r == ST_RDATA)
            begin
              shift_r  <= (cmd_r[CMD_BITS-1:1] == '0) ? (cmd_r[0] ? port_in_s[15:8] : port_in_s[7:0])
                                                      : regs_r[cmd_r];
              sda_oe_r <= ~((cmd_r[CMD_BITS-1:1] == '0) ? (cmd_r[0] ? port_in_s[15] : port_in_s[7])
                                                        : regs_r[cmd_r][7]);
            end
          end
        end
        ST_RDATA:
        begin
          if (scl_fall)
          begin
            bit_cnt_r <= bit_cnt_r + 4'h1;
            if (bit_cnt_r == 4'(BYTE_BITS - 1))
            begin
              sda_oe_r  <= 1'b0;
              state_r   <= ST_MACK;
              bit_cnt_r <= 4'h0;
            end
            else
            begin
              shift_r  <= {shift_r[6:0], 1'b0};
              sda_oe_r <= ~shift_r[6];
            end
          end
        end
        ST_MACK:
        begin
          if (scl_rise)
          begin
            if (sda_s)
            begin
              state_r <= ST_SKIP;
            end
            else
            begin
              cmd_r       <= pair_flip(cmd_r);
              state_r     <= ST_ACK;
              after_ack_r <= ST_RDATA;
            end
          end
        end
        default:
        begin
          state_r <= ST_IDLE;
        end
      endcase
    end
  end

  assign bus.sda_oe_s = sda_oe_r;

  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      port_out_o <= 16'h0000;
      port_cfg_o <= 16'hFFFF;
      busy_o     <= 1'b0;
    end
    else
    begin
      port_out_o <= {regs_r[3], regs_r[2]};
      port_cfg_o <= {regs_r[7], regs_r[6]};
      busy_o     <= (state_r != ST_IDLE);
    end
  end
endmodule : twi_expander

// ===== src/twi_master.sv
// Master end of the two-wire link: runs one write or read transaction per request.
// Assumes the far end is the expander; a quarter-period enable divides clk_i for the serial clock.
module twi_master
  import twi_pkg::*;
(
  input  wire logic       clk_i,
  input  wire logic       arst_n_i,
  twi_if.master           bus,
  input  wire logic       req_i,
  input  wire logic       rd_i,
  input  wire logic [6:0] addr_i,
  input  wire logic [2:0] cmd_i,
  input  wire logic [7:0] wdata_i,
  input  wire logic [3:0] count_i,
  output logic            busy_o,
  output logic            done_o,
  output logic            nack_o,
  output logic            rvalid_o,
  output logic [7:0]      rdata_o
);
  typedef enum logic [2:0] {
    M_IDLE  = 3'b000,
    M_START = 3'b001,
    M_BYTE  = 3'b010,
    M_ACK   = 3'b011,
    M_RSTRT = 3'b100,
    M_STOP  = 3'b101
  } mstate_e;

  logic       sda_s;
  mstate_e    st_r;
  logic [7:0] tick_cnt_r;
  logic       tick;
  logic [1:0] ph_r;
  logic [3:0] bit_r;
  logic [7:0] sh_r;
  logic [1:0] stage_r;
  logic [3:0] left_r;
  logic       rd_r;
  logic [6:0] addr_r;
  logic [2:0] cmd_r;
  logic [7:0] wd_r;
  logic       scl_oe_r;
  logic       sda_oe_r;
  logic       ack_r;

  sync2 #(.RESET_VAL(1'b1)) u_sync_sda (.clk_i(clk_i), .arst_n_i(arst_n_i), .d_i(bus.sda), .q_o(sda_s));

  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      tick_cnt_r <= 8'h00;
    else if (tick)
      tick_cnt_r <= 8'h00;
    else
      tick_cnt_r <= tick_cnt_r + 8'h01;
  end
  assign tick = (tick_cnt_r == 8'(QUARTER_CYC - 1));

  // Stage 0 address, 1 command or write data, 2 read address, 3 read data.
  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      st_r <= M_IDLE; ph_r <= 2'h0; bit_r <= 4'h0; sh_r <= 8'h00; stage_r <= 2'h0;
      left_r <= 4'h0; rd_r <= 1'b0; addr_r <= 7'h00; cmd_r <= 3'h0; wd_r <= 8'h00;
      scl_oe_r <= 1'b0; sda_oe_r <= 1'b0; done_o <= 1'b0; nack_o <= 1'b0;
      rvalid_o <= 1'b0; rdata_o <= 8'h00; busy_o <= 1'b0;
      ack_r <= 1'b0;
    end
    else
    begin
      done_o   <= 1'b0;
      rvalid_o <= 1'b0;
      if (st_r == M_IDLE)
      begin
        scl_oe_r <= 1'b0;
        sda_oe_r <= 1'b0;
        if (req_i)
        begin
          st_r <= M_START; ph_r <= 2'h0; busy_o <= 1'b1; nack_o <= 1'b0;
          rd_r <= rd_i; addr_r <= addr_i; cmd_r <= cmd_i; wd_r <= wdata_i;
          left_r <= (count_i == 4'h0) ? 4'h1 : count_i;
        end
      end
      else if (tick)
      begin
        ph_r <= ph_r + 2'h1;
        case (st_r)
          M_START, M_RSTRT:
          begin
            if (ph_r == 2'h0) begin scl_oe_r <= 1'b0; sda_oe_r <= 1'b0; end
            if (ph_r == 2'h1) sda_oe_r <= 1'b1;
            if (ph_r == 2'h2) scl_oe_r <= 1'b1;
            if (ph_r == 2'h3)
            begin
              st_r  <= M_BYTE;
              bit_r <= 4'h0;
              sh_r  <= {addr_r, (st_r == M_RSTRT)};
              stage_r <= (st_r == M_RSTRT) ? 2'h2 : 2'h0;
            end
          end
          M_BYTE, M_ACK:
          begin
            if (ph_r == 2'h0)
              sda_oe_r <= (st_r == M_ACK) ? (stage_r == 2'h3 && left_r != 4'h1)
                                          : (stage_r != 2'h3 && !sh_r[7]);
            if (ph_r == 2'h1) scl_oe_r <= 1'b0;
            if (ph_r == 2'h2 && st_r == M_BYTE) sh_r <= {sh_r[6:0], sda_s};
            // The acknowledge slot is sampled on its own, so read data waiting in sh_r survives it.
            if (ph_r == 2'h2 && st_r == M_ACK) ack_r <= sda_s;
            if (ph_r == 2'h3)
            begin
              scl_oe_r <= 1'b1;
              if (st_r == M_BYTE)
              begin
                bit_r <= bit_r + 4'h1;
                if (bit_r == 4'(BYTE_BITS - 1)) st_r <= M_ACK;
              end
              else if (stage_r == 2'h3)
              begin
                rvalid_o <= 1'b1; rdata_o <= sh_r;
                left_r <= left_r - 4'h1;
                if (left_r == 4'h1) st_r <= M_STOP;
                else begin st_r <= M_BYTE; bit_r <= 4'h0; end
              end
              else if (ack_r)
              begin
                nack_o <= 1'b1; st_r <= M_STOP;
              end
              else if (stage_r == 2'h0)
              begin
                st_r <= M_BYTE; bit_r <= 4'h0; stage_r <= 2'h1;
                sh_r <= {5'h00, cmd_r};
              end
              else if (stage_r == 2'h2)
              begin
                st_r <= M_BYTE; bit_r <= 4'h0; stage_r <= 2'h3; sh_r <= 8'hFF;
              end
              else if (rd_r)
                st_r <= M_RSTRT;
              else if (left_r == 4'h0)
                st_r <= M_STOP;
              else
              begin
                st_r <= M_BYTE; bit_r <= 4'h0; sh_r <= wd_r; left_r <= left_r - 4'h1;
              end
            end
          end
          M_STOP:
          begin
            if (ph_r == 2'h0) sda_oe_r <= 1'b1;
            if (ph_r == 2'h1) scl_oe_r <= 1'b0;
            if (ph_r == 2'h2) sda_oe_r <= 1'b0;
            if (ph_r == 2'h3) begin st_r <= M_IDLE; busy_o <= 1'b0; done_o <= 1'b1; end
          end
          default:
            st_r <= M_IDLE;
        endcase
      end
    end
  end

  assign bus.scl_oe_m = scl_oe_r;
  assign bus.sda_oe_m = sda_oe_r;
endmodule : twi_master

// ===== test/twi_link_props.sv
// Concurrent checks on the two-wire link between the master end and the expander end.
// Assumes the wired bus levels and both ends' pull-down enables, sampled by the system clock.
module twi_link_props
(
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic scl,
  input wire logic sda,
  input wire logic scl_oe_m,
  input wire logic sda_oe_m,
  input wire logic sda_oe_s
);
  timeunit 1ns;
  timeprecision 1ps;

  logic       scl_q_r;
  logic       sda_q_r;
  logic       in_frame_r;
  logic       nacked_r;
  logic [3:0] bitpos_r;
  logic       start_w;
  logic       stop_w;
  logic       rise_w;

  assign start_w = scl && scl_q_r && sda_q_r && !sda;
  assign stop_w  = scl && scl_q_r && !sda_q_r && sda;
  assign rise_w  = scl && !scl_q_r;

  always_ff @(posedge clk_i or negedge arst_n_i)
    if (!arst_n_i)
    begin
      scl_q_r <= 1'h1;
      sda_q_r <= 1'h1;
    end
    else
    begin
      scl_q_r <= scl;
      sda_q_r <= sda;
    end

  // A repeated start resets the bit position but keeps the frame open.
  always_ff @(posedge clk_i or negedge arst_n_i)
    if (!arst_n_i)
      in_frame_r <= 1'h0;
    else if (start_w)
      in_frame_r <= 1'h1;
    else if (stop_w)
      in_frame_r <= 1'h0;

  always_ff @(posedge clk_i or negedge arst_n_i)
    if (!arst_n_i)
      bitpos_r <= 4'h0;
    else if (start_w)
      bitpos_r <= 4'h0;
    else if (rise_w)
      bitpos_r <= (bitpos_r == 4'h8) ? 4'h0 : bitpos_r + 4'h1;

  // Set when the ninth pulse of a byte finds the data line high.
  always_ff @(posedge clk_i or negedge arst_n_i)
    if (!arst_n_i)
      nacked_r <= 1'h0;
    else if (start_w || stop_w)
      nacked_r <= 1'h0;
    else if (rise_w && bitpos_r == 4'h8 && sda)
      nacked_r <= 1'h1;

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!arst_n_i);

  idle_slave_a: assert property (!in_frame_r |-> !sda_oe_s)
    else $error("expander drives data on idle bus");
  idle_clock_a: assert property (!in_frame_r |-> !scl_oe_m)
    else $error("master pulls clock on idle bus");
  idle_data_a: assert property (!in_frame_r && !$fell(sda) |-> !sda_oe_m)
    else $error("master pulls data on idle bus outside a start");
  slave_hold_a: assert property (scl && $past(scl) |-> $stable(sda_oe_s))
    else $error("expander changes data while clock high");
  stop_align_a: assert property (stop_w |-> bitpos_r == 4'h1)
    else $error("stop not after whole bytes");
  restart_align_a: assert property (start_w && in_frame_r |-> bitpos_r == 4'h1)
    else $error("repeated start not after whole bytes");
  nack_release_a: assert property (nacked_r |-> !sda_oe_s)
    else $error("expander drives data after no acknowledge");
  scl_high_a: assert property ($rose(scl) |-> scl[*8])
    else $error("clock high phase too short");
  scl_period_a: assert property (in_frame_r && $fell(scl) |-> ##[1:1000] (scl || !in_frame_r))
    else $error("clock stalls low in frame");
endmodule : twi_link_props

// ===== test/gpio_expander_i2c_slave_link_tb.sv
// Bench joining the master end and the expander end over one open-drain bus.
// Assumes the package timing: one serial bit takes 1000 system clocks.
module gpio_expander_i2c_slave_link_tb
  import twi_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  localparam logic [2:0] PINS = 3'h5;

  logic        clk_i = 1'h0;
  logic        arst_n_i = 1'h0;
  logic        req_i;
  logic        rd_i;
  logic [6:0]  addr_i;
  logic [2:0]  cmd_i;
  logic [7:0]  wdata_i;
  logic [3:0]  count_i;
  logic [15:0] port_in_i;
  logic        done_o;
  logic        nack_o;
  logic        rvalid_o;
  logic [7:0]  rdata_o;
  logic        mst_busy;
  logic        exp_busy;
  logic [15:0] port_out_o;
  logic [15:0] port_cfg_o;
  logic [7:0]  got_q [$];
  int          miscompares = 0;
  int          samples_checked = 0;

  always #5 clk_i = ~clk_i;

  twi_if bus();

  twi_master twi_master_inst (.clk_i(clk_i), .arst_n_i(arst_n_i), .bus(bus), .req_i(req_i), .rd_i(rd_i),
    .addr_i(addr_i), .cmd_i(cmd_i), .wdata_i(wdata_i), .count_i(count_i), .busy_o(mst_busy), .done_o(done_o),
    .nack_o(nack_o), .rvalid_o(rvalid_o), .rdata_o(rdata_o));

  twi_expander twi_expander_inst (.clk_i(clk_i), .arst_n_i(arst_n_i), .bus(bus), .addr_pins_i(PINS),
    .port_in_i(port_in_i), .port_out_o(port_out_o), .port_cfg_o(port_cfg_o), .busy_o(exp_busy));

  twi_link_props twi_link_props_inst (.clk_i(clk_i), .arst_n_i(arst_n_i), .scl(bus.scl), .sda(bus.sda),
    .scl_oe_m(bus.scl_oe_m), .sda_oe_m(bus.sda_oe_m), .sda_oe_s(bus.sda_oe_s));

  task chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  // Inputs other than req_i stay put until done; the master captures them in the cycle it accepts the request.
  task xfer(input logic rd, input logic [6:0] a, input logic [2:0] c, input logic [7:0] d, input logic [3:0] n);
    int i;
    got_q = {};
    @(posedge clk_i);
    req_i <= 1'h1;
    rd_i <= rd;
    addr_i <= a;
    cmd_i <= c;
    wdata_i <= d;
    count_i <= n;
    @(posedge clk_i);
    req_i <= 1'h0;
    #1;
    chk("busy_start", {15'h0, mst_busy}, 16'h1);
    for (i = 0; i < 60000; i++)
    begin
      @(posedge clk_i);
      #1;
      if (rvalid_o === 1'h1)
        got_q.push_back(rdata_o);
      if (done_o === 1'h1)
        break;
    end
    chk("done", {15'h0, done_o}, 16'h1);
    chk("busy_end", {14'h0, mst_busy, exp_busy}, 16'h0);
  endtask : xfer

  task close_out();
    if (miscompares == 0 && samples_checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : close_out

  initial
  begin
    #1_100_000;
    miscompares++;
    close_out();
  end

  initial
  begin
    req_i = 1'h0;
    rd_i = 1'h0;
    addr_i = 7'h00;
    cmd_i = 3'h0;
    wdata_i = 8'h00;
    count_i = 4'h0;
    port_in_i = 16'h3C96;
    repeat (6) @(posedge clk_i);
    arst_n_i <= 1'h1;
    #1;
    chk("bus_idle", {14'h0, bus.scl, bus.sda}, 16'h3);
    chk("cfg_reset", port_cfg_o, 16'hFFFF);
    chk("out_reset", port_out_o, 16'h0000);
    xfer(1'h0, {ADDR_FIXED, PINS}, 3'h3, 8'hA5, 4'h2);
    chk("write_nack", {15'h0, nack_o}, 16'h0);
    chk("out_pair", port_out_o, 16'hA5A5);
    xfer(1'h1, {ADDR_FIXED, PINS}, 3'h0, 8'h00, 4'h2);
    chk("read_count", 16'(got_q.size()), 16'h2);
    chk("read_b0", {8'h0, got_q[0]}, 16'h0096);
    chk("read_b1", {8'h0, got_q[1]}, 16'h003C);
    chk("read_nack", {15'h0, nack_o}, 16'h0);
    xfer(1'h0, {ADDR_FIXED, ~PINS}, 3'h2, 8'h00, 4'h1);
    chk("foreign_nack", {15'h0, nack_o}, 16'h1);
    chk("foreign_out", port_out_o, 16'hA5A5);
    chk("cfg_kept", port_cfg_o, 16'hFFFF);
    close_out();
  end
endmodule : gpio_expander_i2c_slave_link_tb
